// [include/pal_pkg.sv]
package pal_pkg;

	// ------------------------------------------------------------
	// sizes and timing
	// ------------------------------------------------------------
	localparam int          NUM_ALARMS     = 2;
	localparam int          VAL_W          = 20;   // signed display value, decimal point ignored
	localparam int          COLOUR_W       = 3;    // preset colour 1..7
	localparam int          SEC_W          = 12;   // 0..3600 seconds
	localparam int          CLK_HZ         = 200_000_000;
	localparam int          SEC_PER_TICK   = 1;    // delay and silence step in seconds
	localparam int          TICK_CYCLES    = CLK_HZ * SEC_PER_TICK;
	localparam logic [11:0] MAX_SECONDS    = 12'he10;  // 3600
	localparam int          FLASH_HALF_SEC = 1;    // annunciator blink half period
	localparam int          CODE_W         = 16;   // four bcd digits

	// ------------------------------------------------------------
	// register offsets (plain register port)
	// ------------------------------------------------------------
	localparam logic [4:0] REG_CTRL0   = 5'h00;
	localparam logic [4:0] REG_SETP0   = 5'h01;
	localparam logic [4:0] REG_HYST0   = 5'h02;
	localparam logic [4:0] REG_TIME0   = 5'h03;
	localparam logic [4:0] REG_CTRL1   = 5'h04;
	localparam logic [4:0] REG_SETP1   = 5'h05;
	localparam logic [4:0] REG_HYST1   = 5'h06;
	localparam logic [4:0] REG_TIME1   = 5'h07;
	localparam logic [4:0] REG_GLOBAL  = 5'h08;
	localparam logic [4:0] REG_STATUS  = 5'h09;
	localparam logic [4:0] REG_IRQ_ST  = 5'h0a;
	localparam logic [4:0] REG_IRQ_MSK = 5'h0b;
	localparam logic [4:0] REG_SPCODE  = 5'h0c;
	localparam logic [4:0] REG_SPUNLK  = 5'h0d;
	localparam int         CH_STRIDE   = 4;

	// ctrl field positions
	localparam int CTL_EN      = 0;
	localparam int CTL_LOW     = 1;
	localparam int CTL_NE      = 2;  // relay energised in non alarm
	localparam int CTL_FLASH   = 3;
	localparam int CTL_LATCH   = 4;
	localparam int CTL_COL_LSB = 8;
	// global field positions
	localparam int GLB_LBD     = 0;  // loop break detect enable
	localparam int GLB_DSA     = 1;  // direct setpoint access enable

	// irq status bits per channel: activated, cleared
	localparam int IRQ_W = 4;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [2:0]
	{
		ST_IDLE    = 3'b000,
		ST_DELAY   = 3'b001,
		ST_ACTIVE  = 3'b010,
		ST_SILENCE = 3'b011,
		ST_LATCHED = 3'b100
	} pal_state_e;

	typedef struct packed
	{
		logic [COLOUR_W-1:0] colour;
		logic                latch;
		logic                flash;
		logic                energ_normal;
		logic                low;
		logic                enable;
	} pal_cfg_s;

	typedef struct packed
	{
		logic [SEC_W-1:0] silence;
		logic [SEC_W-1:0] delay;
	} pal_time_s;

endpackage : pal_pkg

// [rtl/pal_alarms.sv]
`timescale 1ns/1ps
// What this block does
// RL1 - two identical alarms, each high or low
// RL2 - loop break forces both relays de-energised
// RL3 - annunciator lights whenever alarm occurs
// RL4 - compare against tared displayed value
// RL5 - enable gates action, parameters kept
// RL6 - alarm starts when value reaches setpoint
// RL7 - polarity picks relay state in normal
// RL8 - hysteresis in display units for clearing
// RL9 - delay between condition and output
// RL10 - accept holds output off for silence
// RL11 - flash shows alarm id while active
// RL12 - latched output released by program button
// RL13 - display takes alarm colour while active
// RL14 - direct setpoint access with own code
// RL15 - high clears below setpoint minus hysteresis
// RL16 - delay 0..3600 s, annunciator flashes
// RL17 - silence 0..3600 s, reactivate if persisting
// RL18 - both active shows second alarm colour
// RL19 - low alarm mirrors high with hysteresis
module pal_alarms
(
	input  wire logic                               i_mclk,
	input  wire logic                               i_rstn,
	input  wire logic signed [pal_pkg::VAL_W-1:0]   i_disp_value,
	input  wire logic                               i_loop_break,
	input  wire logic                               i_display_mode,
	input  wire logic                               i_btn_program,
	input  wire logic                               i_ds_write,
	input  wire logic                               i_ds_sel,
	input  wire logic signed [pal_pkg::VAL_W-1:0]   i_ds_value,
	input  wire logic        [4:0]                  i_addr,
	input  wire logic        [31:0]                 i_wdata,
	input  wire logic                               i_wr,
	input  wire logic                               i_rd,
	output logic             [31:0]                 o_rdata,
	output logic             [1:0]                  o_relay,
	output logic             [1:0]                  o_annunciator,
	output logic             [1:0]                  o_show_alarm_id,
	output logic                                    o_colour_valid,
	output logic             [pal_pkg::COLOUR_W-1:0] o_colour,
	output logic                                    o_irq
);

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	// register index to channel; only meaningful for addresses below global
	function automatic logic addr_ch(input logic [4:0] a);
		addr_ch = a[2];
	endfunction : addr_ch

	function automatic logic [1:0] addr_fld(input logic [4:0] a);
		addr_fld = a[1:0];
	endfunction : addr_fld

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	pal_pkg::pal_cfg_s                    cfg_ff      [2];
	logic signed [pal_pkg::VAL_W-1:0]     setp_ff     [2];
	logic signed [pal_pkg::VAL_W-1:0]     hyst_ff     [2];
	pal_pkg::pal_time_s                   time_ff     [2];
	logic        [1:0]                    glb_ff;
	logic        [pal_pkg::CODE_W-1:0]    spcode_ff;
	logic                                 sp_unlock_ff;
	logic        [pal_pkg::IRQ_W-1:0]     irq_st_ff;
	logic        [pal_pkg::IRQ_W-1:0]     irq_msk_ff;
	pal_pkg::pal_state_e                  state_ff    [2];
	logic        [pal_pkg::SEC_W-1:0]     secs_ff     [2];
	logic        [31:0]                   tick_cnt_ff;
	logic                                 tick_ff;
	logic                                 blink_ff;
	logic        [1:0]                    active_ev;
	logic        [1:0]                    clear_ev;
	logic        [1:0]                    out_on;
	logic        [1:0]                    btn_prev_ff;
	logic                                 btn_rise;
	logic                                 prg_in_disp;

	wire reg_in_ch = (i_addr < pal_pkg::REG_GLOBAL);

	// ------------------------------------------------------------
	// configuration writes
	// ------------------------------------------------------------
	// direct setpoint path only works while enabled and unlocked
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			for (int c = 0; c < 2; c++)
			begin
				cfg_ff[c]  <= '0;
				setp_ff[c] <= '0;
				hyst_ff[c] <= '0;
				time_ff[c] <= '0;
			end
			glb_ff       <= '0;
			spcode_ff    <= '0;
			sp_unlock_ff <= 1'b0;
		end
		else
		begin
			if (i_wr && reg_in_ch)
			begin
				case (addr_fld(i_addr))
					2'h0:    cfg_ff[addr_ch(i_addr)]  <= {i_wdata[pal_pkg::CTL_COL_LSB+:pal_pkg::COLOUR_W],
					                                      i_wdata[pal_pkg::CTL_LATCH:0]};
					2'h1:    setp_ff[addr_ch(i_addr)] <= i_wdata[pal_pkg::VAL_W-1:0];
					2'h2:    hyst_ff[addr_ch(i_addr)] <= i_wdata[pal_pkg::VAL_W-1:0];
					default: time_ff[addr_ch(i_addr)] <= i_wdata[2*pal_pkg::SEC_W-1:0];
				endcase
			end
			if (i_wr && i_addr == pal_pkg::REG_GLOBAL)
				glb_ff <= i_wdata[1:0];
			if (i_wr && i_addr == pal_pkg::REG_SPCODE)
				spcode_ff <= i_wdata[pal_pkg::CODE_W-1:0];
			// the access code is separate from the configuration code  // see RL14
			if (i_wr && i_addr == pal_pkg::REG_SPUNLK)
				sp_unlock_ff <= (i_wdata[pal_pkg::CODE_W-1:0] == spcode_ff);
			if (!i_display_mode)
				sp_unlock_ff <= 1'b0;
			if (i_ds_write && glb_ff[pal_pkg::GLB_DSA] && sp_unlock_ff && i_display_mode)
				setp_ff[i_ds_sel] <= i_ds_value;  // see RL14
		end
	end

	// ------------------------------------------------------------
	// one second tick and blink
	// ------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			tick_cnt_ff <= '0;
			tick_ff     <= 1'b0;
			blink_ff    <= 1'b0;
		end
		else
		begin
			tick_ff <= (tick_cnt_ff == 32'(pal_pkg::TICK_CYCLES - 1));
			if (tick_cnt_ff == 32'(pal_pkg::TICK_CYCLES - 1))
			begin
				tick_cnt_ff <= '0;
				blink_ff    <= ~blink_ff;
			end
			else
				tick_cnt_ff <= tick_cnt_ff + 32'h1;
		end
	end

	// program button edge, counted only in display mode
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
			btn_prev_ff <= '0;
		else
			btn_prev_ff <= {btn_prev_ff[0], i_btn_program};
	end
	assign btn_rise    = btn_prev_ff[0] & ~btn_prev_ff[1];
	assign prg_in_disp = btn_rise & i_display_mode;

	// ------------------------------------------------------------
	// per channel alarm state machine
	// ------------------------------------------------------------
	for (genvar g = 0; g < pal_pkg::NUM_ALARMS; g++)  // see RL1
	begin : g_ch
		logic signed [pal_pkg::VAL_W:0] val_x;
		logic signed [pal_pkg::VAL_W:0] sp_x;
		logic signed [pal_pkg::VAL_W:0] hy_x;
		logic                           trip;
		logic                           hold;
		assign val_x = {i_disp_value[pal_pkg::VAL_W-1], i_disp_value};  // see RL4
		assign sp_x  = {setp_ff[g][pal_pkg::VAL_W-1], setp_ff[g]};
		assign hy_x  = {hyst_ff[g][pal_pkg::VAL_W-1], hyst_ff[g]};
		// trip on equality; stay until past the hysteresis band
		assign trip = cfg_ff[g].low ? (val_x <= sp_x) : (val_x >= sp_x);  // see RL6 see RL19
		assign hold = cfg_ff[g].low ? (val_x <= sp_x + hy_x)  // see RL19
		                            : (val_x >= sp_x - hy_x); // see RL15 see RL8

		always_ff @(posedge i_mclk or negedge i_rstn)
		begin
			if (!i_rstn)
			begin
				state_ff[g] <= pal_pkg::ST_IDLE;
				secs_ff[g]  <= '0;
			end
			else if (!cfg_ff[g].enable)
			begin
				state_ff[g] <= pal_pkg::ST_IDLE;  // see RL5
				secs_ff[g]  <= '0;
			end
			else
			begin
				case (state_ff[g])
					pal_pkg::ST_IDLE:
						if (trip)
						begin
							secs_ff[g]  <= '0;
							state_ff[g] <= (time_ff[g].delay == '0) ? pal_pkg::ST_ACTIVE
							                                       : pal_pkg::ST_DELAY;
						end
					pal_pkg::ST_DELAY:
						if (!trip)
							state_ff[g] <= pal_pkg::ST_IDLE;  // see RL16
						else if (tick_ff)
						begin
							secs_ff[g] <= secs_ff[g] + 12'h1;
							if (secs_ff[g] + 12'h1 >= time_ff[g].delay)
								state_ff[g] <= pal_pkg::ST_ACTIVE;  // see RL9
						end
					pal_pkg::ST_ACTIVE:
						if (prg_in_disp && time_ff[g].silence != '0)
						begin
							secs_ff[g]  <= '0;
							state_ff[g] <= pal_pkg::ST_SILENCE;  // see RL10
						end
						else if (!hold)
							state_ff[g] <= cfg_ff[g].latch ? pal_pkg::ST_LATCHED
							                               : pal_pkg::ST_IDLE;  // see RL12
					pal_pkg::ST_SILENCE:
						if (!hold)
							state_ff[g] <= pal_pkg::ST_IDLE;
						else if (tick_ff)
						begin
							secs_ff[g] <= secs_ff[g] + 12'h1;
							if (secs_ff[g] + 12'h1 >= time_ff[g].silence)
								state_ff[g] <= pal_pkg::ST_ACTIVE;  // see RL17
						end
					pal_pkg::ST_LATCHED:
						if (prg_in_disp)
							state_ff[g] <= pal_pkg::ST_IDLE;  // see RL12
					default:
						state_ff[g] <= pal_pkg::ST_IDLE;
				endcase
			end
		end

		assign out_on[g]    = (state_ff[g] == pal_pkg::ST_ACTIVE) ||
		                      (state_ff[g] == pal_pkg::ST_LATCHED);
		assign active_ev[g] = ~out_on[g] & cfg_ff[g].enable & (
		                      (state_ff[g] == pal_pkg::ST_IDLE && trip &&
		                       time_ff[g].delay == '0) ||
		                      (state_ff[g] == pal_pkg::ST_DELAY && trip && tick_ff &&
		                       secs_ff[g] + 12'h1 >= time_ff[g].delay));
		assign clear_ev[g]  = out_on[g] & cfg_ff[g].enable &
		                      (state_ff[g] == pal_pkg::ST_ACTIVE) & ~hold & ~cfg_ff[g].latch;
	end

	// ------------------------------------------------------------
	// front panel and relay outputs
	// ------------------------------------------------------------
	// relays fall back to de-energised on loop break, the fail-safe state
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_relay         <= '0;
			o_annunciator   <= '0;
			o_show_alarm_id <= '0;
			o_colour_valid  <= 1'b0;
			o_colour        <= '0;
		end
		else
		begin
			for (int c = 0; c < 2; c++)
			begin
				o_relay[c] <= (glb_ff[pal_pkg::GLB_LBD] && i_loop_break) ? 1'b0  // see RL2
				              : (cfg_ff[c].energ_normal ^ out_on[c]);            // see RL7
				o_annunciator[c] <= out_on[c] ||  // see RL3
				    ((state_ff[c] == pal_pkg::ST_DELAY ||
				      state_ff[c] == pal_pkg::ST_SILENCE) && blink_ff);  // see RL16
				o_show_alarm_id[c] <= cfg_ff[c].flash && out_on[c] &&   // see RL11
				    (blink_ff ^ (c[0] & out_on[0]));  // both on: ids take turns
			end
			o_colour_valid <= |out_on;  // see RL13
			o_colour       <= out_on[1] ? cfg_ff[1].colour : cfg_ff[0].colour;  // see RL18
		end
	end

	// ------------------------------------------------------------
	// interrupts: sticky status, write one to clear, set wins
	// ------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			irq_st_ff  <= '0;
			irq_msk_ff <= '0;
			o_irq      <= 1'b0;
		end
		else
		begin
			irq_st_ff <= (irq_st_ff & ~((i_wr && i_addr == pal_pkg::REG_IRQ_ST) ?
			             i_wdata[pal_pkg::IRQ_W-1:0] : 4'h0)) | {clear_ev, active_ev};
			if (i_wr && i_addr == pal_pkg::REG_IRQ_MSK)
				irq_msk_ff <= i_wdata[pal_pkg::IRQ_W-1:0];
			o_irq <= |(irq_st_ff & irq_msk_ff);
		end
	end

	// ------------------------------------------------------------
	// read port, data valid the cycle after the strobe
	// ------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
			o_rdata <= '0;
		else if (i_rd)
		begin
			o_rdata <= '0;
			if (reg_in_ch)
			begin
				case (addr_fld(i_addr))
					2'h0:    o_rdata <= {21'h0, cfg_ff[addr_ch(i_addr)].colour, 3'h0,
					                     cfg_ff[addr_ch(i_addr)][4:0]};
					2'h1:    o_rdata <= 32'(setp_ff[addr_ch(i_addr)]);
					2'h2:    o_rdata <= 32'(hyst_ff[addr_ch(i_addr)]);
					default: o_rdata <= {8'h0, time_ff[addr_ch(i_addr)]};
				endcase
			end
			else
			begin
				case (i_addr)
					pal_pkg::REG_GLOBAL:  o_rdata <= {30'h0, glb_ff};
					pal_pkg::REG_STATUS:  o_rdata <= {21'h0, sp_unlock_ff, out_on,
					                                  2'h0, state_ff[1], state_ff[0]};
					pal_pkg::REG_IRQ_ST:  o_rdata <= {28'h0, irq_st_ff};
					pal_pkg::REG_IRQ_MSK: o_rdata <= {28'h0, irq_msk_ff};
					pal_pkg::REG_SPCODE:  o_rdata <= {16'h0, spcode_ff};
					default:              o_rdata <= '0;
				endcase
			end
		end
	end

endmodule : pal_alarms

// [verification/pal_alarms_props.sv]
`timescale 1ns/1ps
module pal_alarms_props
(
	input wire logic                         i_mclk,
	input wire logic                         i_rstn,
	input wire logic                         i_loop_break,
	input wire logic [4:0]                   i_addr,
	input wire logic [31:0]                  i_wdata,
	input wire logic                         i_wr,
	input wire logic                         i_rd,
	input wire logic [31:0]                  o_rdata,
	input wire logic [1:0]                   o_relay,
	input wire logic [1:0]                   o_annunciator,
	input wire logic [1:0]                   o_show_alarm_id,
	input wire logic                         o_colour_valid,
	input wire logic [pal_pkg::COLOUR_W-1:0] o_colour
);
	// ------------------------------------------------------------
	// shadow of the written configuration
	// ------------------------------------------------------------
	logic [10:0] ctl0_ff, ctl1_ff;
	logic        lbd_ff, cfg_wr, settled, act0, act1;
	logic [2:0]  age_ff;

	assign cfg_wr = i_wr && (i_addr inside {pal_pkg::REG_CTRL0, pal_pkg::REG_CTRL1,
		pal_pkg::REG_GLOBAL});
	// outputs lag config and loop break, so judge them only after things settle
	assign settled = (age_ff == 3'h7);
	assign act0 = settled && ctl0_ff[0] && (o_relay[0] != ctl0_ff[2]);
	assign act1 = settled && ctl1_ff[0] && (o_relay[1] != ctl1_ff[2]);

	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			ctl0_ff <= 11'h000;
			ctl1_ff <= 11'h000;
			lbd_ff  <= 1'b0;
			age_ff  <= 3'h0;
		end
		else
		begin
			if (i_wr && i_addr == pal_pkg::REG_CTRL0)
				ctl0_ff <= i_wdata[10:0];
			if (i_wr && i_addr == pal_pkg::REG_CTRL1)
				ctl1_ff <= i_wdata[10:0];
			if (i_wr && i_addr == pal_pkg::REG_GLOBAL)
				lbd_ff <= i_wdata[0];
			if (cfg_wr || i_loop_break)
				age_ff <= 3'h0;
			else if (age_ff != 3'h7)
				age_ff <= age_ff + 3'h1;
		end
	end

	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);

	lbd_force_a: assert property ((lbd_ff && i_loop_break) [*3]
		|-> o_relay == 2'b00) else $error("relay kept on loop break");
	annun_on_a: assert property (act0 |-> o_annunciator[0])
		else $error("annunciator dark in alarm");
	off_quiet_a: assert property (settled && !ctl0_ff[0]
		|-> o_relay[0] == ctl0_ff[2] && !o_annunciator[0]) else $error("disabled alarm acts");
	idle_pol_a: assert property (settled && !ctl1_ff[0] |-> o_relay[1] == ctl1_ff[2])
		else $error("relay polarity wrong at rest");
	id_flash_a: assert property (settled && o_show_alarm_id[0]
		|-> ctl0_ff[3] && act0) else $error("alarm id shown without active flash alarm");
	id_turns_a: assert property (act0 && act1 && ctl0_ff[3] && ctl1_ff[3]
		|-> ^o_show_alarm_id) else $error("alarm ids not shown in turn");
	col_one_a: assert property (act0 && !act1
		|-> o_colour_valid && o_colour == ctl0_ff[10:8]) else $error("alarm colour wrong");
	col_both_a: assert property (act0 && act1
		|-> o_colour_valid && o_colour == ctl1_ff[10:8]) else $error("second colour not shown");
	rdata_hold_a: assert property (!$past(i_rd) |-> $stable(o_rdata))
		else $error("read data moved without read");
endmodule : pal_alarms_props

bind pal_alarms pal_alarms_props u_props
(
	.i_mclk(i_mclk), .i_rstn(i_rstn), .i_loop_break(i_loop_break), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_relay(o_relay),
	.o_annunciator(o_annunciator), .o_show_alarm_id(o_show_alarm_id),
	.o_colour_valid(o_colour_valid), .o_colour(o_colour)
);

// [verification/pal_alarms_tb_top.sv]
`timescale 1ns/1ps
module pal_alarms_tb_top;
	logic                             i_mclk, i_rstn, i_loop_break, i_display_mode, i_ds_sel;
	logic                             i_ds_write, i_wr, i_rd, press_req, btn, o_colour_valid;
	logic                             o_irq;
	logic signed [pal_pkg::VAL_W-1:0] disp, value_req, i_ds_value;
	logic [4:0]                       i_addr;
	logic [31:0]                      i_wdata, o_rdata, rd_val;
	logic [1:0]                       o_relay, o_annunciator, o_show_alarm_id;
	logic [pal_pkg::COLOUR_W-1:0]     o_colour;
	int                               err_total, checks_done;

	pal_panel_model u_panel
	(
		.i_mclk(i_mclk), .i_rstn(i_rstn), .i_value_req(value_req), .i_press_req(press_req),
		.o_disp_value(disp), .o_btn_program(btn)
	);
	pal_alarms uut
	(
		.i_mclk(i_mclk), .i_rstn(i_rstn), .i_disp_value(disp), .i_loop_break(i_loop_break),
		.i_display_mode(i_display_mode), .i_btn_program(btn), .i_ds_write(i_ds_write),
		.i_ds_sel(i_ds_sel), .i_ds_value(i_ds_value), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_relay(o_relay),
		.o_annunciator(o_annunciator), .o_show_alarm_id(o_show_alarm_id),
		.o_colour_valid(o_colour_valid), .o_colour(o_colour), .o_irq(o_irq)
	);

	// ------------------------------------------------------------
	// bus and check helpers
	// ------------------------------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	task wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		{i_addr, i_wdata, i_wr} <= {a, d, 1'b1};
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask : wr
	// read data appears the cycle after the strobe and holds until the next read
	task rchk(input logic [4:0] a, input logic [31:0] exp, input string what);
		@(posedge i_mclk);
		{i_addr, i_rd} <= {a, 1'b1};
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1 rd_val = o_rdata;
		chk(rd_val, exp, what);
	endtask : rchk
	task setv(input int v);
		@(posedge i_mclk);
		value_req <= pal_pkg::VAL_W'(v);
		repeat (8) @(posedge i_mclk);
	endtask : setv
	task press;
		@(posedge i_mclk);
		press_req <= 1'b1;
		@(posedge i_mclk);
		press_req <= 1'b0;
		repeat (12) @(posedge i_mclk);
	endtask : press
	task cfg(input int ch, input logic [31:0] ctl, sp, hy, tm);
		logic [4:0] b;
		b = 5'(ch * pal_pkg::CH_STRIDE);
		wr(b + pal_pkg::REG_SETP0, sp);
		wr(b + pal_pkg::REG_HYST0, hy);
		wr(b + pal_pkg::REG_TIME0, tm);
		wr(b, ctl);
	endtask : cfg

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task t_regs;
		rchk(pal_pkg::REG_CTRL0, 32'h0, "ctrl reset");
		wr(5'h1f, 32'hffff);
		rchk(5'h1f, 32'h0, "unmapped");
		$display("test regs done");
	endtask : t_regs
	// ch0 high, energised at rest, colour 3
	task t_high;
		cfg(0, 32'h30d, 32'd900, 32'd5, 32'h0);
		setv(899);
		chk(32'(o_relay), 32'h1, "rest");
		setv(900);
		chk(32'({o_relay, o_annunciator}), 32'h1, "trip");
		chk(32'({o_colour_valid, o_colour}), 32'hb, "colour");
		setv(895);
		chk(32'(o_relay), 32'h0, "hyst hold");
		setv(894);
		chk(32'(o_relay), 32'h1, "hyst clear");
		$display("test high done");
	endtask : t_high
	// ch1 low at 1000, hysteresis 10, flash, colour 5; enabled above its setpoint so it starts at rest
	task t_both;
		setv(1001);
		cfg(1, 32'h50f, 32'd1000, 32'd10, 32'h0);
		setv(1001);
		chk(32'(o_relay), 32'h2, "low rest");
		setv(950);
		chk(32'({o_relay, o_colour_valid, o_colour}), 32'hd, "both");
		chk(32'(^o_show_alarm_id), 32'h1, "ids take turns");
		setv(1010);
		chk(32'(o_relay), 32'h0, "low hold");
		setv(1011);
		chk(32'(o_relay), 32'h2, "low clear");
		wr(pal_pkg::REG_CTRL1, 32'h0);
		$display("test both done");
	endtask : t_both
	task t_irq;
		rchk(pal_pkg::REG_IRQ_ST, 32'hf, "irq events");
		wr(pal_pkg::REG_IRQ_MSK, 32'h0);
		repeat (3) @(posedge i_mclk);
		chk(32'(o_irq), 32'h0, "masked");
		wr(pal_pkg::REG_IRQ_MSK, 32'hf);
		repeat (3) @(posedge i_mclk);
		chk(32'(o_irq), 32'h1, "mask effect");
		wr(pal_pkg::REG_IRQ_ST, 32'hf);
		rchk(pal_pkg::REG_IRQ_ST, 32'h0, "irq clear");
		chk(32'(o_irq), 32'h0, "irq low");
		$display("test irq done");
	endtask : t_irq
	task t_lbd;
		setv(0);
		wr(pal_pkg::REG_GLOBAL, 32'h1);
		i_loop_break <= 1'b1;
		repeat (8) @(posedge i_mclk);
		chk(32'(o_relay), 32'h0, "loop break");
		i_loop_break <= 1'b0;
		repeat (8) @(posedge i_mclk);
		chk(32'(o_relay), 32'h1, "loop ok");
		wr(pal_pkg::REG_GLOBAL, 32'h0);
		$display("test lbd done");
	endtask : t_lbd
	task t_latch;
		cfg(0, 32'h31d, 32'd900, 32'd5, 32'h0);
		setv(900);
		setv(0);
		press;
		chk(32'(o_relay), 32'h0, "latched");
		i_display_mode <= 1'b1;
		press;
		chk(32'(o_relay), 32'h1, "unlatched");
		$display("test latch done");
	endtask : t_latch
	task t_accept;
		cfg(0, 32'h30d, 32'd900, 32'd5, 32'h0);
		setv(900);
		press;
		chk(32'(o_relay), 32'h0, "no accept");
		wr(pal_pkg::REG_TIME0, 32'h5000);
		press;
		chk(32'(o_relay), 32'h1, "silenced");
		rchk(pal_pkg::REG_STATUS, 32'h3, "silence state");
		$display("test accept done");
	endtask : t_accept
	task t_disable;
		setv(0);
		setv(900);
		wr(pal_pkg::REG_CTRL0, 32'h30c);
		repeat (8) @(posedge i_mclk);
		chk(32'({o_relay, o_annunciator}), 32'h4, "disabled");
		rchk(pal_pkg::REG_SETP0, 32'd900, "kept");
		wr(pal_pkg::REG_CTRL0, 32'h30d);
		repeat (8) @(posedge i_mclk);
		chk(32'(o_relay), 32'h0, "re-enabled");
		// a 3 s delay cannot run out within this run, so the alarm must wait in delay
		wr(pal_pkg::REG_TIME0, 32'h3);
		setv(0);
		setv(900);
		chk(32'(o_relay), 32'h1, "delay holds");
		rchk(pal_pkg::REG_STATUS, 32'h1, "delay state");
		$display("test disable done");
	endtask : t_disable
	task t_direct;
		wr(pal_pkg::REG_SPCODE, 32'h1234);
		wr(pal_pkg::REG_GLOBAL, 32'h2);
		for (int n = 0; n < 2; n++)
		begin
			@(posedge i_mclk);
			{i_ds_value, i_ds_write} <= {20'sd500, 1'b1};
			@(posedge i_mclk);
			i_ds_write <= 1'b0;
			rchk(pal_pkg::REG_SETP0, n == 1 ? 32'd500 : 32'd900, "direct");
			wr(pal_pkg::REG_SPUNLK, 32'h1234);
		end
		$display("test direct done");
	endtask : t_direct

	task tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish

	initial
	begin
		i_mclk = 1'b0;
		forever #2.5 i_mclk = ~i_mclk;
	end
	// hang guard, far beyond the few hundred cycles the tests need
	initial
	begin
		repeat (40000) @(posedge i_mclk);
		err_total++;
		tally_and_finish;
	end
	initial
	begin
		{i_rstn, i_loop_break, i_display_mode, i_ds_write, i_ds_sel, i_wr, i_rd, press_req} = '0;
		{i_addr, i_wdata, value_req, i_ds_value} = '0;
		repeat (3) @(posedge i_mclk);
		i_rstn <= 1'b1;
		t_regs;
		t_high;
		t_both;
		t_irq;
		t_lbd;
		t_latch;
		t_accept;
		t_disable;
		t_direct;
		tally_and_finish;
	end
endmodule : pal_alarms_tb_top

// [verification/pal_panel_model.sv]
`timescale 1ns/1ps
module pal_panel_model
(
	input  wire logic                             i_mclk,
	input  wire logic                             i_rstn,
	input  wire logic signed [pal_pkg::VAL_W-1:0] i_value_req,
	input  wire logic                             i_press_req,
	output logic signed [pal_pkg::VAL_W-1:0]      o_disp_value,
	output logic                                  o_btn_program
);
	// ------------------------------------------------------------
	// display source and operator
	// ------------------------------------------------------------
	logic [2:0] hold_ff;

	// a press is held for several clocks, as a finger would, so the edge is seen
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			hold_ff       <= 3'h0;
			o_disp_value  <= '0;
			o_btn_program <= 1'b0;
		end
		else
		begin
			o_disp_value <= i_value_req;
			if (i_press_req)
				hold_ff <= 3'h5;
			else if (hold_ff != 3'h0)
				hold_ff <= hold_ff - 3'h1;
			o_btn_program <= (hold_ff != 3'h0);
		end
	end
endmodule : pal_panel_model
